// ### aux_timer_trio_pkg.sv
// Purpose: Constants shared by the three auxiliary timers: register map, fields, resets, divides.
// Assumes: 8-bit special-function-register bus, one system clock.
// Notes: Every offset, field position and divide is named once here.
// Contract
// RL1 - Timer two capture pair latches count bytes on capture; holds reload otherwise.
// RL2 - Timer three is a 16-bit up-counter of two addressable byte registers.
// RL3 - Timer three ticks from oscillator/8, system clock, or system clock/12.
// RL4 - Oscillator select bit 0 set picks oscillator/8 and ignores prescale bit.
// RL5 - With oscillator select clear, prescale bit 0 gives /12, 1 gives /1.
// RL6 - Timer three always auto-reloads from its low and high reload registers.
// RL7 - Timer three wrap sets overflow flag bit 7; only software clears it.
// RL8 - Set timer three flag with interrupt enabled raises an interrupt request.
// RL9 - Timer three run bit 2 stops counting at 0, counts at 1.
// RL10 - Timer three control bits 6 to 3 read zero and ignore writes.
// RL11 - Timer three has no pin event counting mode.
// RL12 - Timer three overflow event is exported to other blocks.
// RL13 - Timer four is a 16-bit counter of two addressable byte registers.
// RL14 - Timer four counts pin falling edges, or system clock /1 or /12.
// RL15 - Running with both UART bits clear: capture bit picks capture or reload.
// RL16 - Either UART clock bit set while running makes timer four a baud generator.
// RL17 - Capture mode needs capture select bit 0 and run bit 2 set.
// RL18 - Trigger falling edge in capture mode copies count, sets external flag, interrupts.
// RL19 - Trigger enable bit 3 clear makes timer four ignore the trigger pin.
// RL20 - Timer four wrap sets overflow flag bit 7 and interrupts if enabled.
// RL21 - No timer four overflow flag in baud mode; flags cleared only by software.
// RL22 - Timer four reload mode loads the capture pair into the counter on wrap.
// RL23 - Timer three loads its reload pair in the very cycle of overflow.
// RL24 - Pin edges and oscillator are synchronised before edge detection.
// RL25 - Software writes to a counter byte beat increment or reload that cycle.
`default_nettype none

package aux_timer_trio_pkg;

	localparam logic [7:0] ADDR_T3_CTL = 8'h91;
	localparam logic [7:0] ADDR_T3_RL_LO = 8'h92;
	localparam logic [7:0] ADDR_T3_RL_HI = 8'h93;
	localparam logic [7:0] ADDR_T3_CNT_LO = 8'h94;
	localparam logic [7:0] ADDR_T3_CNT_HI = 8'h95;
	localparam logic [7:0] ADDR_T2_CAP_LO = 8'hCA;
	localparam logic [7:0] ADDR_T2_CAP_HI = 8'hCB;
	localparam logic [7:0] ADDR_T2_CNT_LO = 8'hCC;
	localparam logic [7:0] ADDR_T2_CNT_HI = 8'hCD;
	localparam logic [7:0] ADDR_T4_CTL = 8'hC9;
	localparam logic [7:0] ADDR_T4_CAP_LO = 8'hE4;
	localparam logic [7:0] ADDR_T4_CAP_HI = 8'hE5;
	localparam logic [7:0] ADDR_T4_CNT_LO = 8'hF4;
	localparam logic [7:0] ADDR_T4_CNT_HI = 8'hF5;
	localparam logic [7:0] ADDR_CLK_PRE = 8'h8E;

	// Timer three control fields.
	localparam int T3_OSC_SEL_BIT = 0;
	localparam int T3_PRE_SEL_BIT = 1;
	localparam int T3_RUN_BIT = 2;
	localparam int T3_FLAG_BIT = 7;
	localparam logic [7:0] T3_CTL_MASK = 8'h87;

	// Timer four control fields.
	localparam int T4_CAPREL_BIT = 0;
	localparam int T4_SRC_BIT = 1;
	localparam int T4_RUN_BIT = 2;
	localparam int T4_TRIG_EN_BIT = 3;
	localparam int T4_UART_TX_BIT = 4;
	localparam int T4_UART_RX_BIT = 5;
	localparam int T4_EXT_FLAG_BIT = 6;
	localparam int T4_FLAG_BIT = 7;

	// Clock prescale control fields.
	localparam int CLK_PRE_T2_BIT = 5;
	localparam int CLK_PRE_T4_BIT = 6;
	localparam logic [7:0] CLK_PRE_MASK = 8'h60;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;

	localparam int SYS_DIV = 12;
	localparam int OSC_DIV = 8;
	localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
	localparam logic [2:0] OSC_DIV_LAST = 3'(OSC_DIV - 1);

endpackage

`default_nettype wire

// ### aux_timer_trio.sv
// Purpose: Timer two capture and count bytes, auto-reload timer three, counter/timer four.
// Assumes: Register port is the processor's byte-wide register bus on REF_CLK.
// Notes: Read data follows the address one clock later; pins are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module aux_timer_trio (
	input wire logic REF_CLK, // System clock, 250 MHz.
	input wire logic RST, // Asynchronous reset, active high.
	input wire logic [7:0] SFR_ADDR, // Register address.
	input wire logic SFR_WR, // Write strobe, one cycle.
	input wire logic [7:0] SFR_WDATA, // Write data.
	output logic [7:0] SFR_RDATA, // Read data of the previous cycle's address.
	input wire logic OSC_IN, // External oscillator, asynchronous.
	input wire logic T4_COUNT_PIN, // Timer four count pin, asynchronous.
	input wire logic T4_TRIGGER_PIN, // Timer four trigger pin, asynchronous.
	input wire logic T2_CAPTURE_MODE, // Timer two is in capture mode.
	input wire logic T2_CAPTURE_EVT, // Timer two capture event, one cycle.
	input wire logic T3_IRQ_EN, // Timer three interrupt enable.
	input wire logic T4_IRQ_EN, // Timer four interrupt enable.
	output logic T3_IRQ, // Timer three interrupt request.
	output logic T4_IRQ, // Timer four interrupt request.
	output logic T3_OVF_PULSE, // Timer three overflow, one cycle.
	output logic T4_BAUD_TICK // Timer four baud overflow, one cycle.
);

	typedef enum {T4_OFF, T4_CAPTURE, T4_RELOAD, T4_BAUD} t4_mode_t;

	typedef struct packed {
		logic [7:0] t3_ctl;
		logic [15:0] t3_rl;
		logic [15:0] t3_cnt;
		logic [15:0] t2_cap;
		logic [15:0] t2_cnt;
		logic [7:0] t4_ctl;
		logic [15:0] t4_cap;
		logic [15:0] t4_cnt;
		logic [7:0] clk_pre;
		logic [3:0] pre12;
		logic [2:0] osc_div;
		logic half;
		logic [2:0] osc_sh;
		logic osc_lvl;
		logic [2:0] cnt_sh;
		logic cnt_lvl;
		logic [2:0] trg_sh;
		logic trg_lvl;
		logic [7:0] rdata;
		logic t3_ovf;
		logic t4_baud;
		logic t3_irq;
		logic t4_irq;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// A level is accepted only once the second and third stages agree.
	function automatic logic settle(input logic [2:0] sh, input logic lvl);
		settle = (sh[1] == sh[2]) ? sh[2] : lvl;
	endfunction

	function automatic logic fell(input logic old_lvl, input logic new_lvl);
		fell = old_lvl & ~new_lvl;
	endfunction

	// Byte write into one half of a 16-bit register.
	function automatic logic [15:0] put_byte(input logic [15:0] cur, input logic hi,
		input logic [7:0] b);
		put_byte = hi ? {b, cur[7:0]} : {cur[15:8], b};
	endfunction

	logic wr_t3_ctl, wr_t3_cnt_lo, wr_t3_cnt_hi, wr_t4_ctl, wr_t4_cnt_lo, wr_t4_cnt_hi;
	logic wr_t2_cap_lo, wr_t2_cap_hi, wr_t4_cap_lo, wr_t4_cap_hi;
	logic pre_tick, osc_tick, t3_tick, t3_wrap, t4_tick, t4_wrap, t4_trig, cnt_fall;
	t4_mode_t t4_mode;

	assign wr_t3_ctl = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T3_CTL;
	assign wr_t3_cnt_lo = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T3_CNT_LO;
	assign wr_t3_cnt_hi = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T3_CNT_HI;
	assign wr_t4_ctl = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T4_CTL;
	assign wr_t4_cnt_lo = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T4_CNT_LO;
	assign wr_t4_cnt_hi = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T4_CNT_HI;
	assign wr_t2_cap_lo = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T2_CAP_LO;
	assign wr_t2_cap_hi = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T2_CAP_HI;
	assign wr_t4_cap_lo = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T4_CAP_LO;
	assign wr_t4_cap_hi = SFR_WR && SFR_ADDR == aux_timer_trio_pkg::ADDR_T4_CAP_HI;

	assign pre_tick = s_r.pre12 == aux_timer_trio_pkg::SYS_DIV_LAST;
	// The oscillator must run below a quarter of REF_CLK for every edge to be seen.
	assign osc_tick = (s_r.osc_div == aux_timer_trio_pkg::OSC_DIV_LAST)
		&& !s_r.osc_lvl && settle(s_r.osc_sh, s_r.osc_lvl); // see RL24
	assign cnt_fall = fell(s_r.cnt_lvl, settle(s_r.cnt_sh, s_r.cnt_lvl)); // see RL24

	// Timer three source: oscillator/8 overrides the prescale choice.
	assign t3_tick = s_r.t3_ctl[aux_timer_trio_pkg::T3_RUN_BIT] && // see RL9
		(s_r.t3_ctl[aux_timer_trio_pkg::T3_OSC_SEL_BIT] ? osc_tick : // see RL3 see RL4 see RL11
		(s_r.t3_ctl[aux_timer_trio_pkg::T3_PRE_SEL_BIT] ? 1'b1 : pre_tick)); // see RL5
	assign t3_wrap = t3_tick && s_r.t3_cnt == aux_timer_trio_pkg::COUNT_TOP
		&& !wr_t3_cnt_lo && !wr_t3_cnt_hi;

	always_comb begin
		if (!s_r.t4_ctl[aux_timer_trio_pkg::T4_RUN_BIT]) begin
			t4_mode = T4_OFF;
		end else if (s_r.t4_ctl[aux_timer_trio_pkg::T4_UART_RX_BIT]
			|| s_r.t4_ctl[aux_timer_trio_pkg::T4_UART_TX_BIT]) begin
			t4_mode = T4_BAUD; // see RL16
		end else if (s_r.t4_ctl[aux_timer_trio_pkg::T4_CAPREL_BIT]) begin
			t4_mode = T4_CAPTURE; // see RL15 see RL17
		end else begin
			t4_mode = T4_RELOAD; // see RL15
		end
	end

	// Baud mode on the system clock runs from REF_CLK/2.
	assign t4_tick = (t4_mode != T4_OFF) && (s_r.t4_ctl[aux_timer_trio_pkg::T4_SRC_BIT] ? cnt_fall :
		(t4_mode == T4_BAUD ? s_r.half :
		(s_r.clk_pre[aux_timer_trio_pkg::CLK_PRE_T4_BIT] ? 1'b1 : pre_tick))); // see RL14
	assign t4_wrap = t4_tick && s_r.t4_cnt == aux_timer_trio_pkg::COUNT_TOP
		&& !wr_t4_cnt_lo && !wr_t4_cnt_hi;
	assign t4_trig = (t4_mode != T4_OFF) && s_r.t4_ctl[aux_timer_trio_pkg::T4_TRIG_EN_BIT] // see RL19
		&& fell(s_r.trg_lvl, settle(s_r.trg_sh, s_r.trg_lvl));

	always_comb begin
		logic t3_set, t4_set, ext_set;
		t3_set = 1'b0;
		t4_set = 1'b0;
		ext_set = 1'b0;
		s_nxt = s_r;
		s_nxt.t3_ovf = 1'b0;
		s_nxt.t4_baud = 1'b0;

		s_nxt.osc_sh = {s_r.osc_sh[1:0], OSC_IN}; // see RL24
		s_nxt.cnt_sh = {s_r.cnt_sh[1:0], T4_COUNT_PIN};
		s_nxt.trg_sh = {s_r.trg_sh[1:0], T4_TRIGGER_PIN};
		s_nxt.osc_lvl = settle(s_r.osc_sh, s_r.osc_lvl);
		s_nxt.cnt_lvl = settle(s_r.cnt_sh, s_r.cnt_lvl);
		s_nxt.trg_lvl = settle(s_r.trg_sh, s_r.trg_lvl);
		s_nxt.pre12 = pre_tick ? 4'h0 : s_r.pre12 + 4'h1;
		s_nxt.half = ~s_r.half;
		if (!s_r.osc_lvl && s_nxt.osc_lvl) begin
			s_nxt.osc_div = s_r.osc_div + 3'h1;
		end

		// Timer three counter: a byte write wins over the tick in the same cycle.
		if (wr_t3_cnt_lo || wr_t3_cnt_hi) begin
			s_nxt.t3_cnt = put_byte(s_r.t3_cnt, wr_t3_cnt_hi, SFR_WDATA); // see RL25 see RL2
		end else if (t3_wrap) begin
			s_nxt.t3_cnt = s_r.t3_rl; // see RL6 see RL23
			t3_set = 1'b1; // see RL7
			s_nxt.t3_ovf = 1'b1; // see RL12
		end else if (t3_tick) begin
			s_nxt.t3_cnt = s_r.t3_cnt + 16'h0001; // see RL2
		end

		// Timer four counter: write, then trigger, then tick.
		if (wr_t4_cnt_lo || wr_t4_cnt_hi) begin
			s_nxt.t4_cnt = put_byte(s_r.t4_cnt, wr_t4_cnt_hi, SFR_WDATA); // see RL25 see RL13
		end else if (t4_trig && t4_mode == T4_RELOAD) begin
			s_nxt.t4_cnt = s_r.t4_cap;
		end else if (t4_wrap) begin
			s_nxt.t4_cnt = (t4_mode == T4_CAPTURE) ? 16'h0000 : s_r.t4_cap; // see RL22
			t4_set = (t4_mode != T4_BAUD); // see RL20 see RL21
			s_nxt.t4_baud = (t4_mode == T4_BAUD); // see RL16
		end else if (t4_tick) begin
			s_nxt.t4_cnt = s_r.t4_cnt + 16'h0001; // see RL13 see RL14
		end
		ext_set = t4_trig;
		if (wr_t4_cap_lo || wr_t4_cap_hi) begin
			s_nxt.t4_cap = put_byte(s_r.t4_cap, wr_t4_cap_hi, SFR_WDATA);
		end else if (t4_trig && t4_mode == T4_CAPTURE) begin
			s_nxt.t4_cap = s_r.t4_cnt; // see RL18
		end

		// Timer two: software bytes, plus capture when the mode logic asks for it.
		if (wr_t2_cap_lo || wr_t2_cap_hi) begin
			s_nxt.t2_cap = put_byte(s_r.t2_cap, wr_t2_cap_hi, SFR_WDATA);
		end else if (T2_CAPTURE_MODE && T2_CAPTURE_EVT) begin
			s_nxt.t2_cap = s_r.t2_cnt; // see RL1
		end

		if (SFR_WR) begin
			case (SFR_ADDR)
				aux_timer_trio_pkg::ADDR_T3_CTL: begin
					s_nxt.t3_ctl = SFR_WDATA & aux_timer_trio_pkg::T3_CTL_MASK; // see RL10
				end
				aux_timer_trio_pkg::ADDR_T3_RL_LO: begin
					s_nxt.t3_rl = put_byte(s_r.t3_rl, 1'b0, SFR_WDATA);
				end
				aux_timer_trio_pkg::ADDR_T3_RL_HI: begin
					s_nxt.t3_rl = put_byte(s_r.t3_rl, 1'b1, SFR_WDATA);
				end
				aux_timer_trio_pkg::ADDR_T2_CNT_LO: begin
					s_nxt.t2_cnt = put_byte(s_r.t2_cnt, 1'b0, SFR_WDATA);
				end
				aux_timer_trio_pkg::ADDR_T2_CNT_HI: begin
					s_nxt.t2_cnt = put_byte(s_r.t2_cnt, 1'b1, SFR_WDATA);
				end
				aux_timer_trio_pkg::ADDR_T4_CTL: begin
					s_nxt.t4_ctl = SFR_WDATA;
				end
				aux_timer_trio_pkg::ADDR_CLK_PRE: begin
					s_nxt.clk_pre = SFR_WDATA & aux_timer_trio_pkg::CLK_PRE_MASK;
				end
				default: begin
				end
			endcase
		end
		// A hardware set in the cycle of a software clear still lands.
		s_nxt.t3_ctl[aux_timer_trio_pkg::T3_FLAG_BIT] =
			s_nxt.t3_ctl[aux_timer_trio_pkg::T3_FLAG_BIT] | t3_set; // see RL7
		s_nxt.t4_ctl[aux_timer_trio_pkg::T4_FLAG_BIT] =
			s_nxt.t4_ctl[aux_timer_trio_pkg::T4_FLAG_BIT] | t4_set; // see RL21
		s_nxt.t4_ctl[aux_timer_trio_pkg::T4_EXT_FLAG_BIT] =
			s_nxt.t4_ctl[aux_timer_trio_pkg::T4_EXT_FLAG_BIT] | ext_set; // see RL18

		s_nxt.t3_irq = T3_IRQ_EN && s_r.t3_ctl[aux_timer_trio_pkg::T3_FLAG_BIT]; // see RL8
		s_nxt.t4_irq = T4_IRQ_EN && (s_r.t4_ctl[aux_timer_trio_pkg::T4_FLAG_BIT]
			|| s_r.t4_ctl[aux_timer_trio_pkg::T4_EXT_FLAG_BIT]); // see RL18 see RL20

		case (SFR_ADDR)
			aux_timer_trio_pkg::ADDR_T3_CTL: s_nxt.rdata = s_r.t3_ctl; // see RL10
			aux_timer_trio_pkg::ADDR_T3_RL_LO: s_nxt.rdata = s_r.t3_rl[7:0];
			aux_timer_trio_pkg::ADDR_T3_RL_HI: s_nxt.rdata = s_r.t3_rl[15:8];
			aux_timer_trio_pkg::ADDR_T3_CNT_LO: s_nxt.rdata = s_r.t3_cnt[7:0];
			aux_timer_trio_pkg::ADDR_T3_CNT_HI: s_nxt.rdata = s_r.t3_cnt[15:8];
			aux_timer_trio_pkg::ADDR_T2_CAP_LO: s_nxt.rdata = s_r.t2_cap[7:0];
			aux_timer_trio_pkg::ADDR_T2_CAP_HI: s_nxt.rdata = s_r.t2_cap[15:8];
			aux_timer_trio_pkg::ADDR_T2_CNT_LO: s_nxt.rdata = s_r.t2_cnt[7:0];
			aux_timer_trio_pkg::ADDR_T2_CNT_HI: s_nxt.rdata = s_r.t2_cnt[15:8];
			aux_timer_trio_pkg::ADDR_T4_CTL: s_nxt.rdata = s_r.t4_ctl;
			aux_timer_trio_pkg::ADDR_T4_CAP_LO: s_nxt.rdata = s_r.t4_cap[7:0];
			aux_timer_trio_pkg::ADDR_T4_CAP_HI: s_nxt.rdata = s_r.t4_cap[15:8];
			aux_timer_trio_pkg::ADDR_T4_CNT_LO: s_nxt.rdata = s_r.t4_cnt[7:0];
			aux_timer_trio_pkg::ADDR_T4_CNT_HI: s_nxt.rdata = s_r.t4_cnt[15:8];
			aux_timer_trio_pkg::ADDR_CLK_PRE: s_nxt.rdata = s_r.clk_pre;
			default: s_nxt.rdata = aux_timer_trio_pkg::RESET_BYTE;
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign SFR_RDATA = s_r.rdata;
	assign T3_IRQ = s_r.t3_irq;
	assign T4_IRQ = s_r.t4_irq;
	assign T3_OVF_PULSE = s_r.t3_ovf;
	assign T4_BAUD_TICK = s_r.t4_baud;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	a_t3_wrap_reload: assert property (t3_wrap |=> s_r.t3_cnt == $past(s_r.t3_rl)
		&& s_r.t3_ovf && s_r.t3_ctl[7]) // see RL23 see RL6 see RL7
		else $error("timer three wrap did not reload and flag");
	a_t3_flag_sticky: assert property (s_r.t3_ctl[7] && !wr_t3_ctl |=> s_r.t3_ctl[7]) // see RL7
		else $error("timer three flag cleared by hardware");
	a_t3_run_stop: assert property (!s_r.t3_ctl[2] && !wr_t3_cnt_lo && !wr_t3_cnt_hi
		|=> $stable(s_r.t3_cnt)) // see RL9
		else $error("timer three counted while stopped");
	a_t3_unused_zero: assert property (s_r.t3_ctl[6:3] == 4'h0) // see RL10
		else $error("timer three unused bits not zero");
	a_t3_osc_source: assert property (t3_tick && s_r.t3_ctl[0] |-> osc_tick) // see RL4
		else $error("timer three ticked off oscillator divider");
	a_t3_prescale: assert property (t3_tick && !s_r.t3_ctl[0] && !s_r.t3_ctl[1]
		|-> pre_tick ##1 !pre_tick [*8]) // see RL5
		else $error("timer three divide by twelve wrong");
	a_t3_irq_raise: assert property (T3_IRQ_EN && s_r.t3_ctl[7] |=> T3_IRQ) // see RL8
		else $error("timer three interrupt missing");
	a_t4_capture_pair: assert property (t4_trig && t4_mode == T4_CAPTURE
		&& !wr_t4_cap_lo && !wr_t4_cap_hi
		|=> s_r.t4_cap == $past(s_r.t4_cnt) && s_r.t4_ctl[6]) // see RL18 see RL17
		else $error("timer four capture failed");
	a_t4_trig_ignored: assert property (!s_r.t4_ctl[3] && !wr_t4_ctl |=> $stable(s_r.t4_ctl[6])
		&& $stable(s_r.t4_cap) || $past(wr_t4_cap_lo || wr_t4_cap_hi)) // see RL19
		else $error("timer four trigger acted while disabled");
	a_t4_baud_noflag: assert property (t4_wrap && t4_mode == T4_BAUD && !wr_t4_ctl
		|=> $stable(s_r.t4_ctl[7]) && T4_BAUD_TICK) // see RL21 see RL16
		else $error("timer four baud flag misbehaved");
	a_t4_reload_wrap: assert property (t4_wrap && t4_mode == T4_RELOAD && !t4_trig
		|=> s_r.t4_cnt == $past(s_r.t4_cap) && s_r.t4_ctl[7]) // see RL22 see RL20
		else $error("timer four reload failed");
	a_t4_pin_count: assert property (t4_tick && s_r.t4_ctl[1] |-> cnt_fall) // see RL14
		else $error("timer four counted without pin edge");
	a_t4_write_wins: assert property (wr_t4_cnt_lo && t4_tick
		|=> s_r.t4_cnt[7:0] == $past(SFR_WDATA)) // see RL25
		else $error("timer four write lost to tick");
	a_t2_capture: assert property (T2_CAPTURE_MODE && T2_CAPTURE_EVT && !wr_t2_cap_lo
		&& !wr_t2_cap_hi |=> s_r.t2_cap == $past(s_r.t2_cnt)) // see RL1
		else $error("timer two capture failed");

	c_t3_wrap: cover property (t3_wrap);
	c_t4_capture: cover property (t4_trig && t4_mode == T4_CAPTURE);
	c_t4_baud: cover property (t4_wrap && t4_mode == T4_BAUD);
	c_t4_reload: cover property (t4_wrap && t4_mode == T4_RELOAD);

endmodule // aux_timer_trio

`default_nettype wire

// ### aux_timer_pins.sv
// Purpose: Far-side model of the timer pins: external oscillator, count pin and trigger pin.
// Assumes: Count and trigger pins idle high as if pulled up; each phase lasts at least four system clocks.
// Notes: The oscillator stands low unless osc_run is high.
`timescale 1ns/1ps
`default_nettype none

module aux_timer_pins (
	input wire logic clk, // System clock.
	input wire logic osc_run, // Oscillator enable.
	output logic osc, // External oscillator, half period of five clocks.
	output logic cnt_pin, // Count pin.
	output logic trg_pin // Trigger pin.
);
	logic [2:0] div_r = 3'h0;
	initial begin
		osc = 1'b0;
		cnt_pin = 1'b1;
		trg_pin = 1'b1;
	end
	// Slow enough that the synchroniser sees every phase.
	always @(posedge clk) begin
		div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
		if (div_r == 3'h4) begin
			osc <= ~osc & osc_run;
		end
	end
	task automatic fall(input bit trg, input int n);
		repeat (n) begin
			@(posedge clk);
			if (trg) trg_pin <= 1'b0;
			else cnt_pin <= 1'b0;
			repeat (4) @(posedge clk);
			if (trg) trg_pin <= 1'b1;
			else cnt_pin <= 1'b1;
			repeat (4) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask
endmodule // aux_timer_pins

`default_nettype wire

// ### aux_timer_trio_tb.sv
// Purpose: Self-checking bench for the three auxiliary timers.
// Assumes: Register reads answer one clock after the address, writes land next clock.
// Notes: Tick-rate checks allow a small tolerance for prescaler phase.
`timescale 1ns/1ps
`default_nettype none

module aux_timer_trio_tb;
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] SFR_ADDR = 8'h00;
	logic SFR_WR = 1'b0;
	logic [7:0] SFR_WDATA = 8'h00;
	logic [7:0] SFR_RDATA;
	logic T2_CAPTURE_MODE = 1'b0;
	logic T2_CAPTURE_EVT = 1'b0;
	logic T3_IRQ_EN = 1'b0;
	logic T4_IRQ_EN = 1'b0;
	logic T3_IRQ, T4_IRQ, T3_OVF_PULSE, T4_BAUD_TICK, osc, cnt_pin, trg_pin;
	logic osc_run = 1'b0;
	int fails = 0;
	int n_checks = 0;
	int baud_n = 0;
	int t3p_n = 0;
	localparam logic [7:0] MAP [16] = '{8'h91, 8'hC9, 8'h8E, 8'h00, 8'h92, 8'h93, 8'h94, 8'h95,
		8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hE4, 8'hE5, 8'hF4, 8'hF5};
	localparam logic [7:0] T4_MODES [5] = '{8'h07, 8'h06, 8'h16, 8'h27, 8'h36};
	localparam int SRC_CTL [4] = '{32'h04, 32'h06, 32'h05, 32'h07};
	localparam int SRC_CYC [4] = '{240, 48, 800, 800};
	localparam int SRC_DIV [4] = '{12, 1, 80, 80};
	localparam logic [7:0] T4_SYS [3] = '{8'h04, 8'h04, 8'h14};
	localparam logic [7:0] T4_PRE [3] = '{8'h00, 8'h40, 8'h00};
	localparam int T4_CYC [3] = '{240, 48, 96};
	localparam int T4_DIV [3] = '{12, 1, 2};

	always #2 REF_CLK = ~REF_CLK;

	aux_timer_trio DUT (.REF_CLK(REF_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
		.SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .OSC_IN(osc), .T4_COUNT_PIN(cnt_pin),
		.T4_TRIGGER_PIN(trg_pin), .T2_CAPTURE_MODE(T2_CAPTURE_MODE),
		.T2_CAPTURE_EVT(T2_CAPTURE_EVT), .T3_IRQ_EN(T3_IRQ_EN), .T4_IRQ_EN(T4_IRQ_EN),
		.T3_IRQ(T3_IRQ), .T4_IRQ(T4_IRQ), .T3_OVF_PULSE(T3_OVF_PULSE),
		.T4_BAUD_TICK(T4_BAUD_TICK));
	aux_timer_pins pins (.clk(REF_CLK), .osc_run(osc_run), .osc(osc), .cnt_pin(cnt_pin),
		.trg_pin(trg_pin));

	always @(posedge REF_CLK) begin
		if (T4_BAUD_TICK === 1'b1) baud_n <= baud_n + 1;
		if (T3_OVF_PULSE === 1'b1) t3p_n <= t3p_n + 1;
	end

	// Count value after a timer four wrap: capture mode clears, the others reload.
	function automatic logic [15:0] t4_wrap(input logic [7:0] c, input logic [15:0] cap);
		return (!(c[5] | c[4]) && c[0]) ? 16'h0000 : cap;
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic near(input string nm, input int e, input logic [15:0] g);
		n_checks++;
		if ($isunknown(g) || int'(g) < e - 2 || int'(g) > e + 2) begin
			fails++;
			$display("[FAIL] %s expected %0d seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		SFR_ADDR <= a;
		SFR_WDATA <= d;
		SFR_WR <= 1'b1;
		@(posedge REF_CLK);
		SFR_WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge REF_CLK);
		SFR_ADDR <= a;
		@(posedge REF_CLK);
		#1 d = SFR_RDATA;
	endtask
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 8'h01, d[15:8]);
	endtask
	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		rd(a, d[7:0]);
		rd(a + 8'h01, d[15:8]);
	endtask
	task automatic done(input string nm);
		$display("test %s finished, %0d mismatches so far", nm, fails);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		logic [15:0] v, w;
		logic [7:0] b;
		int k, i;
		k = $urandom(26);
		repeat (8) @(posedge REF_CLK);
		RST <= 1'b0;
		foreach (MAP[j]) begin
			rd(MAP[j], b);
			chk("reset value", 16'h0000, {8'h00, b});
		end
		done("reset");
		for (i = 4; i < 16; i++) begin
			b = 8'($urandom);
			wr(MAP[i], b);
			rd(MAP[i], v[7:0]);
			chk("byte register", {8'h00, b}, {8'h00, v[7:0]});
		end
		wr(8'h91, 8'h78);
		rd(8'h91, b);
		chk("t3 unused bits", 16'h0000, {8'h00, b});
		wr(8'h8E, 8'hFF);
		rd(8'h8E, b);
		chk("prescale reg", 16'h0060, {8'h00, b});
		wr(8'h00, 8'h55);
		rd(8'h00, b);
		chk("unmapped", 16'h0000, {8'h00, b});
		wr(8'h8E, 8'h00);
		done("registers");
		wr16(8'h92, 16'hFFF0);
		wr16(8'h94, 16'hFFFE);
		T3_IRQ_EN <= 1'b1;
		k = t3p_n;
		wr(8'h91, 8'h06);
		for (i = 0; i < 50 && t3p_n == k; i++) @(posedge REF_CLK);
		wr(8'h91, 8'h82);
		chk("t3 pulses", 16'h0001, 16'(t3p_n - k));
		rd(8'h91, b);
		chk("t3 flag", 16'h0082, {8'h00, b});
		chk("t3 irq", 16'h0001, {15'h0, T3_IRQ});
		rd16(8'h94, v);
		chk("t3 reloaded", 16'h0FFF, {4'h0, v[15:4]});
		wr(8'h91, 8'h02);
		rd(8'h91, b);
		chk("t3 flag clear", 16'h0002, {8'h00, b});
		chk("t3 irq low", 16'h0000, {15'h0, T3_IRQ});
		repeat (30) @(posedge REF_CLK);
		rd16(8'h94, w);
		chk("t3 stopped", v, w);
		done("timer three wrap");
		for (i = 0; i < 4; i++) begin
			wr16(8'h94, 16'h0000);
			osc_run <= SRC_CTL[i][0];
			wr(8'h91, 8'(SRC_CTL[i]));
			repeat (SRC_CYC[i]) @(posedge REF_CLK);
			wr(8'h91, 8'h00);
			rd16(8'h94, v);
			near("t3 tick rate", SRC_CYC[i] / SRC_DIV[i], v);
		end
		done("timer three sources");
		wr16(8'hF4, 16'h0000);
		wr(8'hC9, 8'h06);
		k = 1 + $urandom % 6;
		pins.fall(1'b0, k);
		rd16(8'hF4, v);
		chk("t4 pin count", 16'(k), v);
		wr(8'hC9, 8'h00);
		wr16(8'hF4, 16'h1234);
		wr(8'hC9, 8'h0F);
		T4_IRQ_EN <= 1'b1;
		pins.fall(1'b1, 1);
		rd16(8'hE4, v);
		chk("t4 capture", 16'h1234, v);
		rd(8'hC9, b);
		chk("t4 ext flag", 16'h004F, {8'h00, b});
		chk("t4 irq", 16'h0001, {15'h0, T4_IRQ});
		wr(8'hC9, 8'h07);
		wr16(8'hF4, 16'h5678);
		pins.fall(1'b1, 1);
		rd16(8'hE4, v);
		chk("t4 trigger off", 16'h1234, v);
		rd(8'hC9, b);
		chk("t4 flag cleared", 16'h0007, {8'h00, b});
		done("timer four capture");
		foreach (T4_MODES[j]) begin
			w = 16'($urandom);
			wr16(8'hE4, w);
			wr(8'hC9, T4_MODES[j]);
			wr16(8'hF4, 16'hFFFF);
			k = baud_n;
			pins.fall(1'b0, 1);
			rd16(8'hF4, v);
			chk("t4 wrap count", t4_wrap(T4_MODES[j], w), v);
			rd(8'hC9, b);
			b = (T4_MODES[j][5] | T4_MODES[j][4]) ? T4_MODES[j] : T4_MODES[j] | 8'h80;
			chk("t4 wrap flag", {8'h00, b}, {8'h00, SFR_RDATA});
			chk("t4 baud tick", {15'h0, b[7] == 1'b0}, 16'(baud_n - k));
			chk("t4 wrap irq", {15'h0, b[7]}, {15'h0, T4_IRQ});
			wr(8'hC9, 8'h00);
		end
		// System-clock sources: /12, /1 through the prescale register, and the baud /2 base.
		for (i = 0; i < 3; i++) begin
			wr(8'h8E, T4_PRE[i]);
			wr16(8'hF4, 16'h0000);
			wr(8'hC9, T4_SYS[i]);
			repeat (T4_CYC[i]) @(posedge REF_CLK);
			wr(8'hC9, 8'h00);
			rd16(8'hF4, v);
			near("t4 tick rate", T4_CYC[i] / T4_DIV[i], v);
		end
		wr(8'h8E, 8'h00);
		done("timer four modes");
		v = 16'($urandom);
		wr16(8'hCC, v);
		T2_CAPTURE_MODE <= 1'b1;
		@(posedge REF_CLK);
		T2_CAPTURE_EVT <= 1'b1;
		@(posedge REF_CLK);
		T2_CAPTURE_EVT <= 1'b0;
		T2_CAPTURE_MODE <= 1'b0;
		wr16(8'hCC, ~v);
		@(posedge REF_CLK);
		T2_CAPTURE_EVT <= 1'b1;
		@(posedge REF_CLK);
		T2_CAPTURE_EVT <= 1'b0;
		rd16(8'hCA, w);
		chk("t2 capture", v, w);
		done("timer two");
		end_of_test();
	end
endmodule // aux_timer_trio_tb

`default_nettype wire
